// File: design/pib_irq_bank.sv
// Peripheral interrupt bank: enable group four, request groups one to four,
// gating toward the core, APB register access and a bank interrupt.
// Assumes one clock, synchronous event pulses, enables of groups 1-3 from
// outside, and an APB master that holds its request until pready.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps

// Contract
// [RL1] Flags set on their source event, whatever enable or global state.
// [RL2] Software clears a stale flag before setting its enable.
// [RL3] No peripheral request passes unless the master allow bit is 1.
// [RL4] Enable group four: scanner, checksum, timer B three, timer A three.
// [RL5] Request group one: gate 7, converter 6, capcomp 2, timer 1, overflow 0.
// [RL6] Request group two: comp B 6, comp A 5, timers 2 and 1, capcomp 0.
// [RL7] Request group three: waveform generator 5, zero cross 4.
// [RL8] Request group four uses the same bit positions as enable four.
// [RL9] An implemented flag reads 1 while pending, 0 otherwise.
// [RL10] Unimplemented bits always read zero.
// [RL11] Implemented enable and flag bits are read/write, reset to 0.
// [RL12] Global allow 1 passes enabled interrupts, 0 blocks all; here it gates periph_req only, not the bank interrupt irq.
// [RL13] Request is OR of flag AND enable, gated; writes act next clock.
module pib_irq_bank #(
  parameter bit COMPARATOR_B_PRESENT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pib_pkg::ADDR_W-1:0] paddr,
  input wire logic [pib_pkg::DATA_W-1:0] pwdata,
  output logic [pib_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pib_pkg::BYTE_W-1:0] src_event_g1,
  input wire logic [pib_pkg::BYTE_W-1:0] src_event_g2,
  input wire logic [pib_pkg::BYTE_W-1:0] src_event_g3,
  input wire logic [pib_pkg::BYTE_W-1:0] src_event_g4,
  input wire logic [pib_pkg::BYTE_W-1:0] ext_enable_g1,
  input wire logic [pib_pkg::BYTE_W-1:0] ext_enable_g2,
  input wire logic [pib_pkg::BYTE_W-1:0] ext_enable_g3,
  output logic periph_req,
  output logic irq
);

  localparam logic [pib_pkg::BYTE_W-1:0] REQ2_MASK_EFF = COMPARATOR_B_PRESENT ?
    pib_pkg::REQ2_MASK : (pib_pkg::REQ2_MASK & ~pib_pkg::COMPARATOR_B_MASK);
  localparam logic [pib_pkg::GROUPS-1:0][pib_pkg::BYTE_W-1:0] MASKS = // RL5 RL6 RL7 RL8
    {pib_pkg::GROUP4_MASK, pib_pkg::REQ3_MASK, REQ2_MASK_EFF, pib_pkg::REQ1_MASK};

  function automatic logic hit(input logic [pib_pkg::ADDR_W-1:0] a,
                               input logic [pib_pkg::ADDR_W-1:0] off);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic pready_q;
  logic pslverr_q;
  logic [pib_pkg::DATA_W-1:0] prdata_q;
  logic [pib_pkg::BYTE_W-1:0] enable4_q;
  logic [pib_pkg::BYTE_W-1:0] control_q;
  logic periph_req_q;
  logic [pib_pkg::GROUPS-1:0][pib_pkg::BYTE_W-1:0] flags;
  logic [pib_pkg::ST_W-1:0] st_status;
  logic [pib_pkg::ST_W-1:0] st_enable;
  logic irq_q;

  wire access = psel & penable;
  wire first_acc = access & ~pready_q;
  wire fire = access & pready_q;
  wire wr_fire = fire & pwrite;
  wire [pib_pkg::BYTE_W-1:0] wbyte = pwdata[pib_pkg::BYTE_W-1:0];

  wire sel_en4 = hit(paddr, pib_pkg::OFF_ENABLE4);
  wire sel_ctrl = hit(paddr, pib_pkg::OFF_CONTROL);
  wire sel_st = hit(paddr, pib_pkg::OFF_IRQ_STATUS);
  wire sel_ien = hit(paddr, pib_pkg::OFF_IRQ_ENABLE);
  wire sel_clr = hit(paddr, pib_pkg::OFF_IRQ_CLEAR);
  wire [pib_pkg::GROUPS-1:0] sel_req = {hit(paddr, pib_pkg::OFF_REQ4),
                                        hit(paddr, pib_pkg::OFF_REQ3),
                                        hit(paddr, pib_pkg::OFF_REQ2),
                                        hit(paddr, pib_pkg::OFF_REQ1)};
  wire mapped = sel_en4 | sel_ctrl | sel_st | sel_ien | sel_clr | (|sel_req);

  ////////////////////////////////////////////////////////////////////////////
  // Read selection; unused upper bits and absent positions read zero
  wire [pib_pkg::BYTE_W-1:0] rd_byte =
      sel_en4 ? enable4_q :                                    // RL4
      sel_req[0] ? flags[0] :                                  // RL9
      sel_req[1] ? flags[1] :
      sel_req[2] ? flags[2] :
      sel_req[3] ? flags[3] :
      sel_ctrl ? control_q :
      sel_st ? {{(pib_pkg::BYTE_W-pib_pkg::ST_W){1'b0}}, st_status} :
      sel_ien ? {{(pib_pkg::BYTE_W-pib_pkg::ST_W){1'b0}}, st_enable} :
      pib_pkg::RESET_BYTE;                                     // RL10
  wire [pib_pkg::DATA_W-1:0] rd_word = {{(pib_pkg::DATA_W-pib_pkg::BYTE_W){1'b0}}, rd_byte};

  // One wait state: data is registered in the first access cycle
  wire [pib_pkg::DATA_W-1:0] prdata_d = (first_acc & ~pwrite) ? rd_word : prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= first_acc;
      pslverr_q <= first_acc & ~mapped;
      prdata_q <= prdata_d;
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request flags, one instance per group
  wire [pib_pkg::GROUPS-1:0][pib_pkg::BYTE_W-1:0] events =
      {src_event_g4, src_event_g3, src_event_g2, src_event_g1};

  genvar g;
  generate
    for (g = 0; g < pib_pkg::GROUPS; g++) begin : gen_flag
      pib_flag_reg #(
        .W(pib_pkg::BYTE_W),
        .MASK(MASKS[g])
      ) u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_fire & sel_req[g]),                          // RL13
        .wr_data(wbyte),
        .set_evt(events[g]),                                   // RL1
        .flag_q(flags[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Enable group four and control
  wire [pib_pkg::BYTE_W-1:0] enable4_d = (wr_fire & sel_en4) ? wbyte : enable4_q;
  wire [pib_pkg::BYTE_W-1:0] control_d =
      (wr_fire & sel_ctrl) ? (wbyte & pib_pkg::CONTROL_MASK) : control_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable4_q <= pib_pkg::RESET_BYTE;                        // RL11
      control_q <= pib_pkg::RESET_BYTE;
    end else begin
      enable4_q <= enable4_d;
      control_q <= control_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request toward the core
  wire global_irq_allow = control_q[pib_pkg::GLOBAL_IRQ_ALLOW_BIT];
  wire peripheral_master_allow = control_q[pib_pkg::PERIPHERAL_MASTER_ALLOW_BIT];
  wire [pib_pkg::GROUPS-1:0][pib_pkg::BYTE_W-1:0] enables =
      {enable4_q, ext_enable_g3, ext_enable_g2, ext_enable_g1};
  wire any_pending = |(flags & enables & MASKS);               // RL13
  // Master allow gates the group, global allow sits above it
  wire periph_req_d = global_irq_allow & peripheral_master_allow & any_pending; // RL3 RL12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_req_q <= 1'b0;
    end else begin
      periph_req_q <= periph_req_d;
    end
  end

  assign periph_req = periph_req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bank interrupt on its own events
  wire [pib_pkg::ST_W-1:0] st_evt;
  assign st_evt[pib_pkg::ST_FLAG_SET_BIT] = |(events & MASKS);
  assign st_evt[pib_pkg::ST_REQ_RISE_BIT] = periph_req_d & ~periph_req_q;
  assign st_evt[pib_pkg::ST_BUS_ERR_BIT] = first_acc & ~mapped;

  pib_sticky_irq #(
    .W(pib_pkg::ST_W)
  ) u_sticky (
    .pclk(pclk),
    .presetn(presetn),
    .evt(st_evt),
    .clr_wr(wr_fire & sel_clr),
    .en_wr(wr_fire & sel_ien),
    .wr_data(wbyte[pib_pkg::ST_W-1:0]),
    .status_q(st_status),
    .enable_q(st_enable),
    .irq_q(irq_q)
  );

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rd_first(logic [pib_pkg::ADDR_W-1:0] off);
    psel && penable && !pready && !pwrite && paddr == off;
  endsequence

  sequence s_wr_fire(logic [pib_pkg::ADDR_W-1:0] off);
    psel && penable && pready && pwrite && paddr == off;
  endsequence

  a_flag_on_event: assert property ( // RL1
    (src_event_g4 != 8'h00) |=> ((flags[3] & $past(src_event_g4)) == $past(src_event_g4)))
    else $error("group four flag missed its event");

  a_master_blocks: assert property ( // RL3
    !peripheral_master_allow |=> !periph_req)
    else $error("request passed with master allow clear");

  a_global_blocks: assert property ( // RL12
    !global_irq_allow |=> !periph_req)
    else $error("request passed with global allow clear");

  a_req_combine: assert property ( // RL13
    ##1 periph_req == $past(global_irq_allow && peripheral_master_allow
                            && ((flags[3] & enable4_q) != 8'h00
                                || (flags[2] & ext_enable_g3 & MASKS[2]) != 8'h00
                                || (flags[1] & ext_enable_g2 & MASKS[1]) != 8'h00
                                || (flags[0] & ext_enable_g1 & MASKS[0]) != 8'h00)))
    else $error("combined request does not match flags and enables");

  a_rd_enable4: assert property ( // RL4
    s_rd_first(pib_pkg::OFF_ENABLE4) |=> pready && prdata == {24'h000000, $past(enable4_q)})
    else $error("enable four read mismatch");

  a_rd_req1: assert property ( // RL9
    s_rd_first(pib_pkg::OFF_REQ1) |=> pready && prdata[7:0] == $past(flags[0]))
    else $error("request one read mismatch");

  a_unimpl_zero: assert property ( // RL10
    (flags[0] & 8'h38) == 8'h00 && (flags[1] & 8'h98) == 8'h00
    && (flags[2] & 8'hcf) == 8'h00)
    else $error("unimplemented flag bit set");

  a_layout_req2: assert property ( // RL6
    src_event_g2[0] |=> flags[1][0])
    else $error("capcomp two flag not at bit 0");

  a_layout_req3: assert property ( // RL7
    src_event_g3[5] && src_event_g3[4] |=> flags[2] == 8'h30)
    else $error("group three flags misplaced");

  a_wr_req4_next: assert property ( // RL13
    s_wr_fire(pib_pkg::OFF_REQ4) ##0 (src_event_g4 == 8'h00)
    |=> flags[3] == $past(pwdata[7:0]))
    else $error("flag write not applied next clock");

  a_reset_clear: assert property (disable iff (1'b0) // RL11
    $rose(presetn) |-> flags == '0 && enable4_q == 8'h00 && !periph_req)
    else $error("state not clear after reset");

  // Registered from next status and enable, so a clear write drops it at once
  a_bank_irq: assert property (
    irq == ((st_status & st_enable) != 3'h0))
    else $error("bank interrupt does not follow status and enable");

endmodule

// File: common/pib_pkg.sv
// Constants for the peripheral interrupt enable and flag bank.
// Assumes a 32-bit APB slave with word-aligned registers.
package pib_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned GROUPS = 4;
  localparam int unsigned ST_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ENABLE4 = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_REQ1 = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_REQ2 = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_REQ3 = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_REQ4 = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 6'h20;

  localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
  localparam logic [BYTE_W-1:0] BIT0 = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned GLOBAL_IRQ_ALLOW_BIT = 7;
  localparam int unsigned PERIPHERAL_MASTER_ALLOW_BIT = 6;
  localparam logic [BYTE_W-1:0] CONTROL_MASK = (BIT0 << GLOBAL_IRQ_ALLOW_BIT)
                                             | (BIT0 << PERIPHERAL_MASTER_ALLOW_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Request group one
  localparam int unsigned TIMER_ONE_GATE_PENDING_BIT = 7;
  localparam int unsigned CONVERTER_DONE_PENDING_BIT = 6;
  localparam int unsigned CAPCOMP_ONE_PENDING_BIT = 2;
  localparam int unsigned TIMER_TWO_MATCH_PENDING_BIT = 1;
  localparam int unsigned TIMER_ONE_OVERFLOW_PENDING_BIT = 0;
  localparam logic [BYTE_W-1:0] REQ1_MASK = (BIT0 << TIMER_ONE_GATE_PENDING_BIT)
    | (BIT0 << CONVERTER_DONE_PENDING_BIT) | (BIT0 << CAPCOMP_ONE_PENDING_BIT)
    | (BIT0 << TIMER_TWO_MATCH_PENDING_BIT) | (BIT0 << TIMER_ONE_OVERFLOW_PENDING_BIT);

  // Request group two
  localparam int unsigned COMPARATOR_B_PENDING_BIT = 6;
  localparam int unsigned COMPARATOR_A_PENDING_BIT = 5;
  localparam int unsigned TIMER_SIX_MATCH_PENDING_BIT = 2;
  localparam int unsigned TIMER_FOUR_MATCH_PENDING_BIT = 1;
  localparam int unsigned CAPCOMP_TWO_PENDING_BIT = 0;
  localparam logic [BYTE_W-1:0] COMPARATOR_B_MASK = BIT0 << COMPARATOR_B_PENDING_BIT;
  localparam logic [BYTE_W-1:0] REQ2_MASK = COMPARATOR_B_MASK
    | (BIT0 << COMPARATOR_A_PENDING_BIT) | (BIT0 << TIMER_SIX_MATCH_PENDING_BIT)
    | (BIT0 << TIMER_FOUR_MATCH_PENDING_BIT) | (BIT0 << CAPCOMP_TWO_PENDING_BIT);

  // Request group three
  localparam int unsigned WAVEFORM_GEN_PENDING_BIT = 5;
  localparam int unsigned ZERO_CROSS_PENDING_BIT = 4;
  localparam logic [BYTE_W-1:0] REQ3_MASK = (BIT0 << WAVEFORM_GEN_PENDING_BIT)
    | (BIT0 << ZERO_CROSS_PENDING_BIT);

  // Group four: enable and request share one layout, every bit implemented
  localparam int unsigned SCANNER_BIT = 7;
  localparam int unsigned CHECKSUM_BIT = 6;
  localparam int unsigned MEAS_TIMER_B_WIDTH_BIT = 5;
  localparam int unsigned MEAS_TIMER_B_PERIOD_BIT = 4;
  localparam int unsigned MEAS_TIMER_B_MATCH_BIT = 3;
  localparam int unsigned MEAS_TIMER_A_WIDTH_BIT = 2;
  localparam int unsigned MEAS_TIMER_A_PERIOD_BIT = 1;
  localparam int unsigned MEAS_TIMER_A_MATCH_BIT = 0;
  localparam logic [BYTE_W-1:0] GROUP4_MASK = 8'hff;

  ////////////////////////////////////////////////////////////////////////////
  // Bank interrupt status fields
  localparam int unsigned ST_FLAG_SET_BIT = 0;
  localparam int unsigned ST_REQ_RISE_BIT = 1;
  localparam int unsigned ST_BUS_ERR_BIT = 2;
  localparam logic [ST_W-1:0] ST_RESET = 3'h0;

endpackage

// File: design/pib_flag_reg.sv
// One group of request flags: hardware events set, software writes.
// Assumes event pulses are synchronous to pclk.
`timescale 1ns/1ps
module pib_flag_reg #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] MASK = '1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic [W-1:0] set_evt,
  output logic [W-1:0] flag_q
);

  logic [W-1:0] flag_d;
  wire [W-1:0] base = wr_en ? wr_data : flag_q;

  // Event wins over a write of 0 in the same cycle
  assign flag_d = (base | set_evt) & MASK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule

// File: design/pib_sticky_irq.sv
// Sticky status, enable and write-to-clear for the bank's own interrupt.
// Assumes clear and enable writes are one-cycle strobes.
`timescale 1ns/1ps
module pib_sticky_irq #(
  parameter int unsigned W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] evt,
  input wire logic clr_wr,
  input wire logic en_wr,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] status_q,
  output logic [W-1:0] enable_q,
  output logic irq_q
);

  logic [W-1:0] status_d;
  logic [W-1:0] enable_d;
  wire [W-1:0] clr_bits = clr_wr ? wr_data : '0;

  // Set wins over clear so no event is lost
  assign status_d = (status_q & ~clr_bits) | evt;
  assign enable_d = en_wr ? wr_data : enable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      enable_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      irq_q <= |(status_d & enable_d);
    end
  end

endmodule

// File: bench/pib_event_src.sv
// Model of the peripheral event sources that feed the bank's flag inputs.
// Assumes the bench calls pulse right after a rising pclk edge.
`timescale 1ns/1ps
module pib_event_src (
  input wire logic pclk,
  output logic [pib_pkg::BYTE_W-1:0] src_event_g1,
  output logic [pib_pkg::BYTE_W-1:0] src_event_g2,
  output logic [pib_pkg::BYTE_W-1:0] src_event_g3,
  output logic [pib_pkg::BYTE_W-1:0] src_event_g4
);
  initial begin
    src_event_g1 = '0;
    src_event_g2 = '0;
    src_event_g3 = '0;
    src_event_g4 = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle strobes; the idle edge after them keeps repeated calls apart
  task automatic pulse(input logic [31:0] bits);
    src_event_g4 <= bits[31:24];
    src_event_g3 <= bits[23:16];
    src_event_g2 <= bits[15:8];
    src_event_g1 <= bits[7:0];
    @(posedge pclk);
    src_event_g1 <= '0;
    src_event_g2 <= '0;
    src_event_g3 <= '0;
    src_event_g4 <= '0;
    @(posedge pclk);
  endtask
endmodule

// File: bench/pib_irq_bank_tb_top.sv
// Self-checking bench for the peripheral interrupt bank.
// Assumes the APB slave answers with pready and the event model drives flags.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module pib_irq_bank_tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [pib_pkg::ADDR_W-1:0] paddr;
  logic [pib_pkg::DATA_W-1:0] pwdata;
  logic [pib_pkg::DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [pib_pkg::BYTE_W-1:0] ev1, ev2, ev3, ev4;
  logic [pib_pkg::BYTE_W-1:0] ext_enable_g1, ext_enable_g2, ext_enable_g3;
  logic periph_req;
  logic irq;
  int num_errors = 0;
  int tests_run = 0;
  logic [pib_pkg::ADDR_W-1:0] offs [7];
  logic [pib_pkg::BYTE_W-1:0] msk [7];

  pib_irq_bank pib_irq_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event_g1(ev1),
    .src_event_g2(ev2), .src_event_g3(ev3), .src_event_g4(ev4),
    .ext_enable_g1(ext_enable_g1), .ext_enable_g2(ext_enable_g2),
    .ext_enable_g3(ext_enable_g3), .periph_req(periph_req), .irq(irq));
  pib_event_src pib_event_src_inst (.pclk(pclk), .src_event_g1(ev1),
    .src_event_g2(ev2), .src_event_g3(ev3), .src_event_g4(ev4));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; an idle edge follows each transfer so psel never toggles twice
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    `CHK(r, exp)
    `CHK(e, err)
  endtask

  // Lets a register write reach the registered request outputs
  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(25 * 5000);
    num_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    offs = '{pib_pkg::OFF_ENABLE4, pib_pkg::OFF_REQ1, pib_pkg::OFF_REQ2,
             pib_pkg::OFF_REQ3, pib_pkg::OFF_REQ4, pib_pkg::OFF_CONTROL,
             pib_pkg::OFF_IRQ_ENABLE};
    msk = '{pib_pkg::GROUP4_MASK, pib_pkg::REQ1_MASK, pib_pkg::REQ2_MASK,
            pib_pkg::REQ3_MASK, pib_pkg::GROUP4_MASK, pib_pkg::CONTROL_MASK, 8'h07};
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_enable_g1 = '0;
    ext_enable_g2 = '0;
    ext_enable_g3 = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rd(offs[i], 32'h0, 1'b0);
    for (int i = 0; i < 7; i++) begin
      wr(offs[i], 32'hffff_ffff);
      rd(offs[i], {24'h0, msk[i]}, 1'b0);
      wr(offs[i], 32'h0);
      rd(offs[i], 32'h0, 1'b0);
    end
    // Unmapped place answers with an error and zero data
    rd(6'h24, 32'h0, 1'b1);
    rd(pib_pkg::OFF_IRQ_CLEAR, 32'h0, 1'b0);
    // Every enable off: events still set exactly the implemented flags
    pib_event_src_inst.pulse(32'hffff_ffff);
    for (int i = 1; i < 5; i++) rd(offs[i], {24'h0, msk[i]}, 1'b0);
    `CHK(periph_req, 1'b0)
    for (int i = 1; i < 5; i++) wr(offs[i], 32'h0);
    rd(pib_pkg::OFF_REQ4, 32'h0, 1'b0);
    // One source through both allow bits
    wr(pib_pkg::OFF_ENABLE4, 32'h80);
    wr(pib_pkg::OFF_CONTROL, 32'hc0);
    pib_event_src_inst.pulse(32'h8000_0000);
    settle();
    `CHK(periph_req, 1'b1)
    wr(pib_pkg::OFF_CONTROL, 32'h80);
    settle();
    `CHK(periph_req, 1'b0)
    wr(pib_pkg::OFF_CONTROL, 32'h40);
    settle();
    `CHK(periph_req, 1'b0)
    wr(pib_pkg::OFF_CONTROL, 32'hc0);
    settle();
    `CHK(periph_req, 1'b1)
    wr(pib_pkg::OFF_REQ4, 32'h0);
    settle();
    `CHK(periph_req, 1'b0)
    // Enable and flag of group four pair bit for bit
    for (int b = 0; b < 8; b++) begin
      wr(pib_pkg::OFF_ENABLE4, 32'h1 << b);
      wr(pib_pkg::OFF_REQ4, 32'h1 << b);
      settle();
      `CHK(periph_req, 1'b1)
      wr(pib_pkg::OFF_REQ4, 32'h0);
    end
    wr(pib_pkg::OFF_ENABLE4, 32'h0);
    // Outside enables: unimplemented positions never request
    ext_enable_g1 <= 8'h38;
    pib_event_src_inst.pulse(32'h0000_0038);
    settle();
    `CHK(periph_req, 1'b0)
    ext_enable_g1 <= 8'h01;
    pib_event_src_inst.pulse(32'h0000_0001);
    settle();
    `CHK(periph_req, 1'b1)
    ext_enable_g1 <= 8'h00;
    ext_enable_g3 <= 8'h10;
    wr(pib_pkg::OFF_REQ1, 32'h0);
    pib_event_src_inst.pulse(32'h0010_0000);
    settle();
    `CHK(periph_req, 1'b1)
    // Group two through its outside enable
    ext_enable_g3 <= 8'h00;
    ext_enable_g2 <= 8'h40;
    wr(pib_pkg::OFF_REQ3, 32'h0);
    settle();
    `CHK(periph_req, 1'b0)
    pib_event_src_inst.pulse(32'h0000_4000);
    settle();
    `CHK(periph_req, 1'b1)
    // Bank interrupt: sticky status, masked, then cleared
    rd(pib_pkg::OFF_IRQ_STATUS, 32'h7, 1'b0);
    `CHK(irq, 1'b0)
    wr(pib_pkg::OFF_IRQ_ENABLE, 32'h4);
    settle();
    `CHK(irq, 1'b1)
    wr(pib_pkg::OFF_IRQ_CLEAR, 32'h4);
    settle();
    `CHK(irq, 1'b0)
    rd(pib_pkg::OFF_IRQ_STATUS, 32'h3, 1'b0);
    // Reset in mid-run clears everything again
    wr(pib_pkg::OFF_ENABLE4, 32'hff);
    pib_event_src_inst.pulse(32'hffff_ffff);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(periph_req, 1'b0)
    ext_enable_g2 <= 8'h00;
    for (int i = 0; i < 7; i++) rd(offs[i], 32'h0, 1'b0);
    rd(pib_pkg::OFF_IRQ_STATUS, 32'h0, 1'b0);
    tally_and_finish();
  end
endmodule
